// ### hw/capture_dma_event_pacing.sv
// Capture DMA event pacing for one video capture channel.
// Assumes the capture path reports each value written to the Y, Cb
// and Cr FIFOs, and the DMA controller reports its reads of them.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// RL1: After a request, hold further requests until DMA first reads that FIFO.
// RL2: Video modes: each pixel pair puts two luma, one blue, one red value.
// RL3: Video threshold doubleword is 8, 4 or 6 pixels by packing.
// RL4: Chroma FIFO thresholds are half the programmed field threshold.
// RL5: Raw doubleword is 8, 4, 6 or 2 samples by storage width.
// RL6: Transport stream threshold counts groups of eight byte samples.
// RL7: Raw and transport: single request at threshold; field 2 and counts ignored.
// RL8: Field 2 uses second threshold only when its select enable is set.
// RL9: Fill counts data as written into FIFO, after any filter.
// RL10: Event counter picks threshold for requests and outgoing data counter.
// RL11: After the field's event count, switch to the other field's threshold.
// RL12: Event count register: field 2 in bits 27-16, field 1 in 11-0.
// RL13: Reserved register bits read zero and ignore writes.
// RL14: Event counter restarts at the start of each captured field.
module capture_dma_event_pacing
  import capture_pacing_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  // Capture path
  input wire fifo_write_t fifo_write,
  input wire logic field_start,
  input wire logic field2_active,
  // DMA controller reads, one per FIFO
  input wire dma_req_t dma_read,
  // DMA requests through a two-entry buffer
  output dma_req_t req_data,
  output logic req_valid,
  input wire logic req_ready,
  // Outgoing data counter threshold, in doublewords
  output logic [THR_W-1:0] active_threshold
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] threshold_q;
  logic [31:0] event_count_q;
  logic [4:0] mode_q;
  logic [31:0] rdata_d;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      threshold_q <= THRESHOLD_RESET;
      event_count_q <= EVENT_COUNT_RESET;
      mode_q <= MODE_RESET;
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        THRESHOLD_ADDR: threshold_q <= reg_req.wdata & THRESHOLD_MASK; // [RL13]
        EVENT_COUNT_ADDR: event_count_q <= reg_req.wdata & EVENT_COUNT_MASK; // [RL12] [RL13]
        MODE_ADDR: mode_q <= reg_req.wdata[4:0];
        default: ;
      endcase
    end
  end

  capture_fmt_t fmt;
  logic sel_en;
  logic video_mode;
  assign fmt = capture_fmt_t'(mode_q[MODE_FMT_LSB +: 4]);
  assign sel_en = mode_q[MODE_SEL_EN_BIT];
  assign video_mode = (fmt == FMT_VIDEO_8) || (fmt == FMT_VIDEO_10) || (fmt == FMT_VIDEO_10_DENSE);

  // ----------------------------------------
  // Field and event-set tracking
  // ----------------------------------------
  logic use_thr2_q;
  logic [EVT_W-1:0] sets_q;
  logic set_done;
  logic [EVT_W-1:0] field_sets;
  logic [THR_W-1:0] thr1;
  logic [THR_W-1:0] thr2;

  assign thr1 = threshold_q[THR1_LSB +: THR_W];
  assign thr2 = threshold_q[THR2_LSB +: THR_W];
  assign field_sets = use_thr2_q ? event_count_q[EVT2_LSB +: EVT_W] : event_count_q[EVT1_LSB +: EVT_W];

  // Raw and transport use the field 1 threshold only
  assign active_threshold = (video_mode && use_thr2_q && sel_en) ? thr2 : thr1; // [RL7] [RL8] [RL10]

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sets_q <= '0;
      use_thr2_q <= 1'b0;
    end else if (field_start) begin
      sets_q <= '0; // [RL14]
      use_thr2_q <= field2_active;
    end else if (video_mode && set_done) begin
      if (sets_q + 12'h001 >= field_sets) begin
        sets_q <= '0;
        use_thr2_q <= ~use_thr2_q; // [RL11]
      end else begin
        sets_q <= sets_q + 12'h001; // [RL10]
      end
    end
  end

  // ----------------------------------------
  // Per-FIFO fill, pacing and request
  // ----------------------------------------
  // Bytes per FIFO value: 1 for 8-bit, 2 for halfword, dense packs
  // three values per word (counted in thirds), raw 20-bit takes a word.
  function automatic logic [2:0] value_units(input capture_fmt_t f);
    unique case (f)
      FMT_VIDEO_10, FMT_RAW_16: value_units = 3'h2; // [RL3] [RL5]
      FMT_VIDEO_10_DENSE, FMT_RAW_10_DENSE: value_units = 3'h4; // [RL3] [RL5]
      FMT_RAW_20: value_units = 3'h4; // [RL5]
      default: value_units = 3'h1; // [RL3] [RL5] [RL6]
    endcase
  endfunction

  // Units in one doubleword: 8 bytes, 6 dense values, or 2 raw 20-bit words
  function automatic logic [3:0] dword_units(input capture_fmt_t f);
    if (f == FMT_VIDEO_10_DENSE || f == FMT_RAW_10_DENSE)
      dword_units = 4'h6;
    else if (f == FMT_RAW_20)
      dword_units = 4'h2;
    else
      dword_units = DWORD_BYTES;
  endfunction

  logic [2:0] step;
  logic [3:0] per_dword;
  logic [2:0] wr_vec;
  logic [2:0] rd_vec;
  logic [2:0] hit;
  logic [2:0] armed_q;
  logic [2:0] clear_vec;
  logic [FILL_W-1:0] fill_q [3];
  logic [FILL_W-1:0] limit [3];
  logic buf_in_ready;

  assign step = (fmt == FMT_RAW_20 || fmt == FMT_VIDEO_10_DENSE || fmt == FMT_RAW_10_DENSE) ? 3'h1 : value_units(fmt);
  assign per_dword = dword_units(fmt);
  assign wr_vec = {fifo_write.luma, fifo_write.blue & video_mode, fifo_write.red & video_mode}; // [RL2] [RL9]
  assign rd_vec = {dma_read.luma, dma_read.blue, dma_read.red};

  always_comb begin
    limit[2] = FILL_W'(active_threshold) * FILL_W'(per_dword);
    limit[1] = FILL_W'(active_threshold >> 1) * FILL_W'(per_dword); // [RL4]
    limit[0] = limit[1];
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      hit[i] = armed_q[i] && (limit[i] != '0) && (fill_q[i] >= limit[i]);
    end
  end

  // Chroma events only exist in video modes; only the luma FIFO paces raw
  logic fire;
  assign fire = video_mode ? (hit[2] && hit[1] && hit[0]) : hit[2]; // [RL7]
  assign set_done = fire && buf_in_ready;

  // Only the FIFOs of the set just pushed restart; a FIFO that reached its
  // limit early keeps its fill and arming until its partners catch up.
  assign clear_vec = {set_done, set_done & video_mode, set_done & video_mode}; // [RL2] [RL7]

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (rst || field_start) begin
        fill_q[i] <= '0;
      end else if (wr_vec[i]) begin
        // A value written in the push cycle already counts toward the next set
        fill_q[i] <= clear_vec[i] ? FILL_W'(step) : fill_q[i] + FILL_W'(step); // [RL9]
      end else if (clear_vec[i]) begin
        fill_q[i] <= '0;
      end
    end
  end

  // A read in the push cycle belongs to the previous set, so the push wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      armed_q <= 3'h7;
    end else begin
      armed_q <= (armed_q | rd_vec) & ~clear_vec; // [RL1]
    end
  end

  // ----------------------------------------
  // Two-entry request buffer
  // ----------------------------------------
  dma_req_t buf_q [2];
  logic [1:0] count_q;
  logic rd_ptr_q;
  logic wr_ptr_q;
  logic push;
  logic pop;

  assign buf_in_ready = (count_q != 2'h2);
  assign push = set_done;
  assign pop = req_valid && req_ready;
  assign req_valid = (count_q != 2'h0);
  assign req_data = buf_q[rd_ptr_q];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (push) begin
      buf_q[wr_ptr_q] <= '{luma: 1'b1, blue: video_mode, red: video_mode};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_q <= '0;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
    end else begin
      count_q <= count_q + 2'(push) - 2'(pop);
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop) rd_ptr_q <= ~rd_ptr_q;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_req.addr == THRESHOLD_ADDR) rdata_d = threshold_q;
    else if (reg_req.addr == EVENT_COUNT_ADDR) rdata_d = event_count_q;
    else if (reg_req.addr == MODE_ADDR) rdata_d = {27'h0, mode_q};
    else if (reg_req.addr == STATUS_ADDR) rdata_d = {4'h0, sets_q, 9'h000, use_thr2_q, count_q, 1'b0, armed_q};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) reg_rdata <= '0;
    else if (reg_req.rd) reg_rdata <= rdata_d;
    else reg_rdata <= '0;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Arming: one set per DMA read of each FIFO
  a_hold_until_read: assert property (@(posedge sys_clk) disable iff (rst) // [RL1]
    set_done |=> !hit[2])
    else $error("luma request repeated before a DMA read");
  a_stay_disarmed: assert property (@(posedge sys_clk) disable iff (rst) // [RL1]
    (!armed_q[2] && !rd_vec[2]) |=> !armed_q[2])
    else $error("luma FIFO rearmed without a DMA read");
  a_rearm_on_read: assert property (@(posedge sys_clk) disable iff (rst) // [RL1]
    (rd_vec[2] && !set_done) |=> armed_q[2])
    else $error("luma FIFO not rearmed by a DMA read");
  a_chroma_disarm: assert property (@(posedge sys_clk) disable iff (rst) // [RL1]
    (set_done && video_mode) |=> armed_q[1:0] == 2'h0)
    else $error("chroma FIFOs still armed after a video set");
  a_set_all_three: assert property (@(posedge sys_clk) disable iff (rst) // [RL2]
    (set_done && video_mode) |-> hit == 3'h7)
    else $error("video set pushed before all three FIFOs reached their limits");
  a_fill_counts_writes: assert property (@(posedge sys_clk) disable iff (rst) // [RL9]
    (wr_vec[2] && !set_done && !field_start) |=> fill_q[2] == $past(fill_q[2]) + FILL_W'($past(step)))
    else $error("luma fill did not count a written value");
  a_fill_field_clear: assert property (@(posedge sys_clk) disable iff (rst) // [RL14]
    field_start |=> fill_q[2] == '0 && fill_q[1] == '0 && fill_q[0] == '0)
    else $error("FIFO fill not cleared at field start");

  // Packing: fill units per value and per doubleword
  a_byte_units: assert property (@(posedge sys_clk) disable iff (rst) // [RL3] [RL5] [RL6]
    (fmt == FMT_VIDEO_8 || fmt == FMT_RAW_8 || fmt == FMT_TRANSPORT) |-> step == 3'h1 && per_dword == 4'h8)
    else $error("byte packing does not count eight values per doubleword");
  a_half_step: assert property (@(posedge sys_clk) disable iff (rst) // [RL3] [RL5]
    (fmt == FMT_VIDEO_10 || fmt == FMT_RAW_16) |-> step == 3'h2 && per_dword == 4'h8)
    else $error("halfword packing does not count four values per doubleword");
  a_dense_units: assert property (@(posedge sys_clk) disable iff (rst) // [RL3] [RL5]
    (fmt == FMT_VIDEO_10_DENSE || fmt == FMT_RAW_10_DENSE) |-> step == 3'h1 && per_dword == 4'h6)
    else $error("dense packing does not count six values per doubleword");
  a_word_units: assert property (@(posedge sys_clk) disable iff (rst) // [RL5]
    (fmt == FMT_RAW_20) |-> step == 3'h1 && per_dword == 4'h2)
    else $error("word packing does not count two samples per doubleword");
  a_chroma_half: assert property (@(posedge sys_clk) disable iff (rst) // [RL4]
    !active_threshold[0] |-> (limit[1] << 1) == limit[2] && limit[0] == limit[1])
    else $error("chroma threshold not half of field threshold");

  // Raw and transport pacing
  a_raw_thr1_only: assert property (@(posedge sys_clk) disable iff (rst) // [RL7]
    !video_mode |-> active_threshold == thr1)
    else $error("raw mode used the field 2 threshold");
  a_no_chroma_raw: assert property (@(posedge sys_clk) disable iff (rst) // [RL7]
    (push && !video_mode) |=> !buf_q[$past(wr_ptr_q)].blue)
    else $error("chroma request raised in raw mode");
  a_push_marks_luma: assert property (@(posedge sys_clk) disable iff (rst) // [RL7]
    push |=> buf_q[$past(wr_ptr_q)].luma)
    else $error("pushed set carries no luma request");
  a_raw_no_count: assert property (@(posedge sys_clk) disable iff (rst) // [RL7]
    (!video_mode && !field_start) |=> sets_q == $past(sets_q))
    else $error("event sets counted outside video modes");
  a_zero_thr_quiet: assert property (@(posedge sys_clk) disable iff (rst) // [RL7]
    (active_threshold == '0) |-> !set_done)
    else $error("request pushed with a zero threshold");
  a_req_held: assert property (@(posedge sys_clk) disable iff (rst) // [RL7]
    (req_valid && !req_ready) |=> req_valid && $stable(req_data))
    else $error("stalled request changed or dropped");

  // Threshold selection and event counting
  a_thr2_needs_en: assert property (@(posedge sys_clk) disable iff (rst) // [RL8]
    (!sel_en) |-> active_threshold == thr1)
    else $error("field 2 threshold used without enable");
  a_video_thr2: assert property (@(posedge sys_clk) disable iff (rst) // [RL8]
    (video_mode && sel_en && use_thr2_q) |-> active_threshold == thr2)
    else $error("field 2 threshold not used when selected");
  a_thr1_field1: assert property (@(posedge sys_clk) disable iff (rst) // [RL10]
    !use_thr2_q |-> active_threshold == thr1)
    else $error("field 1 threshold not used in field 1 state");
  a_set_count_step: assert property (@(posedge sys_clk) disable iff (rst) // [RL10]
    (!field_start && video_mode && set_done && sets_q + 12'h001 < field_sets) |=>
      sets_q == $past(sets_q) + 12'h001 && use_thr2_q == $past(use_thr2_q))
    else $error("event set not counted before the programmed count");
  a_field_switch: assert property (@(posedge sys_clk) disable iff (rst) // [RL11]
    (!field_start && video_mode && set_done && sets_q + 12'h001 >= field_sets) |=> use_thr2_q != $past(use_thr2_q))
    else $error("threshold not switched after event count");
  a_field_restart: assert property (@(posedge sys_clk) disable iff (rst) // [RL14]
    field_start |=> sets_q == '0 && use_thr2_q == $past(field2_active))
    else $error("event counter not restarted at field start");

  // Register contents
  a_reserved_thr_zero: assert property (@(posedge sys_clk) disable iff (rst) // [RL13]
    (threshold_q & ~THRESHOLD_MASK) == '0)
    else $error("threshold reserved bits set");
  a_thr_read_zero: assert property (@(posedge sys_clk) disable iff (rst) // [RL13]
    $past(reg_req.rd) && $past(reg_req.addr) == THRESHOLD_ADDR |-> reg_rdata[31:26] == 6'h00 && reg_rdata[15:10] == 6'h00)
    else $error("threshold reserved bits read nonzero");
  a_evt_field_mask: assert property (@(posedge sys_clk) disable iff (rst) // [RL12]
    (event_count_q & ~EVENT_COUNT_MASK) == '0)
    else $error("event count reserved bits set");
  a_reserved_evt_zero: assert property (@(posedge sys_clk) disable iff (rst) // [RL12] [RL13]
    $past(reg_req.rd) && $past(reg_req.addr) == EVENT_COUNT_ADDR |-> reg_rdata[31:28] == 4'h0)
    else $error("event count reserved bits read nonzero");

endmodule
`default_nettype wire

// ### hw/capture_pacing_pkg.sv
// Package for the capture DMA event pacing block.
// Assumes a single clock domain and a plain register port.
package capture_pacing_pkg;

  // ----------------------------------------
  // Register map (word byte addresses)
  // ----------------------------------------
  localparam logic [7:0] THRESHOLD_ADDR = 8'h00;
  localparam logic [7:0] EVENT_COUNT_ADDR = 8'h04;
  localparam logic [7:0] MODE_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0c;

  // ----------------------------------------
  // Field layouts and reset values
  // ----------------------------------------
  localparam int THR1_LSB = 0;
  localparam int THR2_LSB = 16;
  localparam int THR_W = 10;
  localparam int EVT1_LSB = 0;
  localparam int EVT2_LSB = 16;
  localparam int EVT_W = 12;
  localparam logic [31:0] THRESHOLD_MASK = 32'h03ff_03ff;
  localparam logic [31:0] EVENT_COUNT_MASK = 32'h0fff_0fff;
  localparam logic [31:0] THRESHOLD_RESET = 32'h0000_0000;
  localparam logic [31:0] EVENT_COUNT_RESET = 32'h0000_0000;
  localparam int MODE_FMT_LSB = 0;
  localparam int MODE_SEL_EN_BIT = 4;
  localparam logic [4:0] MODE_RESET = 5'h00;

  // Bytes held in one FIFO doubleword
  localparam logic [3:0] DWORD_BYTES = 4'h8;
  localparam int FILL_W = 14;

  // ----------------------------------------
  // Capture formats
  // ----------------------------------------
  typedef enum logic [3:0] {
    FMT_VIDEO_8,
    FMT_VIDEO_10,
    FMT_VIDEO_10_DENSE,
    FMT_RAW_8,
    FMT_RAW_16,
    FMT_RAW_10_DENSE,
    FMT_RAW_20,
    FMT_TRANSPORT
  } capture_fmt_t;

  // One FIFO write from the capture path, after any filter
  typedef struct packed {
    logic luma;
    logic blue;
    logic red;
  } fifo_write_t;

  // DMA request set towards the DMA controller
  typedef struct packed {
    logic luma;
    logic blue;
    logic red;
  } dma_req_t;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage

// ### tb/capture_dma_event_pacing_tb_top.sv
// Self-checking bench for the capture DMA event pacing block.
// Assumes the DMA controller model answers the request stream.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module capture_dma_event_pacing_tb_top;
  import capture_pacing_pkg::*;
  logic sys_clk, rst, field_start, field2_active, req_valid, req_ready, stall, hold_reads;
  reg_req_t reg_req;
  logic [31:0] reg_rdata, rd;
  fifo_write_t fifo_write;
  dma_req_t dma_read, req_data, last_set;
  logic [THR_W-1:0] active_threshold;
  logic [7:0] sets_taken, base;
  int miscompares = 0;
  int num_checks = 0;
  capture_fmt_t fmts[5] = '{FMT_RAW_8, FMT_RAW_16, FMT_RAW_10_DENSE, FMT_RAW_20, FMT_TRANSPORT};
  int per_dword[5] = '{8, 4, 6, 2, 8};

  capture_dma_event_pacing capture_dma_event_pacing_inst (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .fifo_write(fifo_write), .field_start(field_start), .field2_active(field2_active),
    .dma_read(dma_read), .req_data(req_data), .req_valid(req_valid), .req_ready(req_ready),
    .active_threshold(active_threshold));
  dma_ctrl_model dma_ctrl_model_inst (.sys_clk(sys_clk), .rst(rst), .req_data(req_data), .req_valid(req_valid),
    .req_ready(req_ready), .dma_read(dma_read), .stall(stall), .hold_reads(hold_reads),
    .sets_taken(sets_taken), .last_set(last_set));

  // ----------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    reg_req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge sys_clk);
    reg_req <= '0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic set_mode(input capture_fmt_t f, input logic sel);
    reg_write(MODE_ADDR, {27'h0, sel, 4'(f)});
  endtask
  task automatic put(input fifo_write_t w, input int n);
    repeat (n) begin
      fifo_write <= w;
      @(posedge sys_clk);
    end
    fifo_write <= '0;
    @(posedge sys_clk);
  endtask
  task automatic new_field(input logic f2);
    field_start <= 1'b1;
    field2_active <= f2;
    @(posedge sys_clk);
    field_start <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic wait_sets(input logic [7:0] n);
    for (int i = 0; i < 12 && sets_taken !== n; i++) @(posedge sys_clk);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    reg_req = '0;
    fifo_write = '0;
    field_start = 1'b0;
    field2_active = 1'b0;
    stall = 1'b0;
    hold_reads = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    reg_read(EVENT_COUNT_ADDR, rd); `CHK(rd, 32'h0000_0000)
    reg_write(THRESHOLD_ADDR, 32'hffff_ffff);
    reg_read(THRESHOLD_ADDR, rd); `CHK(rd, 32'h03ff_03ff)
    reg_write(EVENT_COUNT_ADDR, 32'hffff_ffff);
    reg_read(EVENT_COUNT_ADDR, rd); `CHK(rd, 32'h0fff_0fff)
    reg_read(8'h10, rd); `CHK(rd, 32'h0000_0000)
    // Video: 16 luma and 8 of each chroma fill thr1=2; reads held back
    reg_write(EVENT_COUNT_ADDR, 32'h0fff_0fff);
    reg_write(THRESHOLD_ADDR, 32'h0000_0002);
    set_mode(FMT_VIDEO_8, 1'b0);
    new_field(1'b0);
    hold_reads <= 1'b1;
    stall <= 1'b1;
    put(3'b111, 8);
    put(3'b100, 7);
    repeat (4) @(posedge sys_clk);
    `CHK(req_valid, 1'b0)
    put(3'b100, 1);
    repeat (6) @(posedge sys_clk);
    `CHK(req_valid, 1'b1)
    `CHK(sets_taken, 8'h00)
    stall <= 1'b0;
    wait_sets(8'h01);
    `CHK(last_set, 3'b111)
    put(3'b111, 8);
    put(3'b100, 8);
    repeat (6) @(posedge sys_clk);
    `CHK(sets_taken, 8'h01)
    hold_reads <= 1'b0;
    wait_sets(8'h02);
    `CHK(sets_taken, 8'h02)
    // Raw and transport: one luma request per programmed doubleword
    reg_write(THRESHOLD_ADDR, 32'h0000_0001);
    for (int k = 0; k < 5; k++) begin
      set_mode(fmts[k], 1'b1);
      new_field(1'b1);
      base = sets_taken;
      put(3'b100, per_dword[k] - 1);
      repeat (4) @(posedge sys_clk);
      `CHK(sets_taken, base)
      put(3'b100, 1);
      wait_sets(base + 8'h01);
      `CHK(sets_taken, base + 8'h01)
      `CHK(last_set, 3'b100)
    end
    // Video 10-bit packings: halfword and dense counts for thr1=2
    reg_write(THRESHOLD_ADDR, 32'h0000_0002);
    for (int k = 0; k < 2; k++) begin
      set_mode(k ? FMT_VIDEO_10_DENSE : FMT_VIDEO_10, 1'b0);
      new_field(1'b0);
      base = sets_taken;
      put(3'b111, 4 + 2 * k);
      put(3'b100, 3 + 2 * k);
      repeat (4) @(posedge sys_clk);
      `CHK(sets_taken, base)
      put(3'b100, 1);
      wait_sets(base + 8'h01);
      `CHK(sets_taken, base + 8'h01)
      `CHK(last_set, 3'b111)
    end
    // Threshold selection per field and after the event count
    reg_write(THRESHOLD_ADDR, 32'h0004_0002);
    reg_write(EVENT_COUNT_ADDR, 32'h0000_0000);
    set_mode(FMT_VIDEO_8, 1'b1);
    new_field(1'b1); `CHK(active_threshold, 10'h004)
    set_mode(FMT_VIDEO_8, 1'b0);
    new_field(1'b1); `CHK(active_threshold, 10'h002)
    set_mode(FMT_VIDEO_8, 1'b1);
    new_field(1'b0); `CHK(active_threshold, 10'h002)
    base = sets_taken;
    put(3'b111, 8);
    put(3'b100, 8);
    wait_sets(base + 8'h01);
    repeat (2) @(posedge sys_clk);
    `CHK(active_threshold, 10'h004)
    reg_read(MODE_ADDR, rd); `CHK(rd, 32'h0000_0010)
    reg_read(STATUS_ADDR, rd); `CHK(rd, 32'h0000_0047)
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### tb/dma_ctrl_model.sv
// DMA controller model for the capture pacing bench.
// Assumes one clock; it takes request sets and reads each flagged FIFO once.
`timescale 1ns/10ps
`default_nettype none
module dma_ctrl_model
  import capture_pacing_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Request stream
  input wire dma_req_t req_data,
  input wire logic req_valid,
  output logic req_ready,
  // FIFO reads
  output dma_req_t dma_read,
  // Bench control and visibility
  input wire logic stall,
  input wire logic hold_reads,
  output logic [7:0] sets_taken,
  output dma_req_t last_set
);
  dma_req_t pend_q;
  logic take;
  // A stalled receiver is how the bench makes the model answer slowly
  assign req_ready = !stall;
  assign take = req_valid && req_ready;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sets_taken <= 8'h00;
      last_set <= '0;
    end else if (take) begin
      sets_taken <= sets_taken + 8'h01;
      last_set <= req_data;
    end
  end
  // Reads may be held back so that the block stays disarmed
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_q <= '0;
      dma_read <= '0;
    end else if (hold_reads) begin
      pend_q <= pend_q | (take ? req_data : '0);
      dma_read <= '0;
    end else begin
      pend_q <= take ? req_data : '0;
      dma_read <= pend_q;
    end
  end
endmodule
`default_nettype wire
